// ===== dsp_user_config_regs_test.sv
`timescale 1ns/1ps
module dsp_user_config_regs_test;
   import dur_pkg::*;
   // Row: self-test code, type, live path flag, fixed word, {cm, dig, res}
   typedef struct packed {logic [3:0] st; logic [1:0] ty; logic live;
      logic [15:0] word; logic [2:0] fl;} dur_row_t;
   localparam dur_row_t ROWS [0:11] = '{
      '{4'h0, 2'h1, 1'b1, 16'h0000, 3'h0},
      '{4'h0, 2'h3, 1'b1, 16'h0000, 3'h0},
      '{4'h1, 2'h1, 1'b1, 16'h0000, 3'h4},
      '{4'h1, 2'h3, 1'b1, 16'h0000, 3'h4},
      '{4'h4, 2'h1, 1'b0, 16'h0000, 3'h0},
      '{4'h5, 2'h1, 1'b0, 16'hAAAA, 3'h0},
      '{4'h6, 2'h3, 1'b0, 16'h5555, 3'h0},
      '{4'h7, 2'h1, 1'b0, 16'hFFFF, 3'h0},
      '{4'hC, 2'h1, 1'b0, 16'h8171, 3'h2},
      '{4'hD, 2'h3, 1'b0, 16'h6C95, 3'h2},
      '{4'hE, 2'h1, 1'b0, 16'h807A, 3'h2},
      '{4'h2, 2'h3, 1'b1, 16'h0000, 3'h1}};
   logic i_mclk = 1'b0, i_reset_n = 1'b0, i_wr_en = 1'b0, i_rd_en = 1'b0;
   logic [7:0] i_addr = 8'h00, i_wdata = 8'h00;
   logic [15:0] i_absolute_pressure = 16'h0000, i_temperature = 16'h0000;
   logic i_dsp_valid = 1'b0, i_int_req = 1'b0;
   logic [7:0] o_rdata, o_lo, o_hi;
   logic o_cm, o_dig_en, o_res, o_out, o_oe, o_pu, o_pd, o_err;
   logic [1:0] o_dig;
   int n_fail = 0, checks_done = 0;
   dur_row_t r;
   logic [15:0] p, t, e;
   dur_config_regs #(.RW(16)) dut (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
      .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .i_addr(i_addr),
      .i_wdata(i_wdata), .o_rdata(o_rdata),
      .i_absolute_pressure(i_absolute_pressure),
      .i_temperature(i_temperature), .i_dsp_valid(i_dsp_valid),
      .o_second_result_low_byte(o_lo), .o_second_result_high_byte(o_hi),
      .o_cm_verify(o_cm), .o_digital_test(o_dig),
      .o_digital_test_en(o_dig_en), .o_self_test_reserved(o_res),
      .i_int_req(i_int_req), .o_int_out(o_out), .o_int_oe(o_oe),
      .o_int_pull_up(o_pu), .o_int_pull_down(o_pd), .o_array_error(o_err));
   // 100 MHz clock
   always #5 i_mclk = ~i_mclk;
   task automatic chk8(input string nm, input logic [7:0] ex,
      input logic [7:0] g);
      checks_done++;
      if (g !== ex)
      begin
         $display("[FAIL] %s expected %h seen %h", nm, ex, g);
         n_fail++;
      end
   endtask
   task automatic chk1(input string nm, input logic ex, input logic g);
      chk8(nm, {7'h00, ex}, {7'h00, g});
   endtask
   // Strobe held until the sampling edge, released by that same edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_mclk) {i_wr_en, i_addr, i_wdata} <= {1'b1, a, d};
      @(posedge i_mclk) i_wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] ex);
      @(posedge i_mclk) {i_rd_en, i_addr} <= {1'b1, a};
      @(posedge i_mclk) i_rd_en <= 1'b0;
      #1 chk8("rdata", ex, o_rdata);
   endtask
   task automatic pulse(input logic [15:0] pp, input logic [15:0] tt);
      @(posedge i_mclk) {i_dsp_valid, i_absolute_pressure} <= {1'b1, pp};
      i_temperature <= tt;
      @(posedge i_mclk) i_dsp_valid <= 1'b0;
      @(posedge i_mclk) #1;
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Watchdog, far beyond the fewer than 200 cycles the run needs
   initial
   begin
      #200000;
      n_fail++;
      finish_test();
   end
   initial
   begin
      repeat (4) @(posedge i_mclk);
      i_reset_n <= 1'b1;
      repeat (3) @(posedge i_mclk);
      rd(ADDR_CFG_FOUR, 8'h00);
      rd(ADDR_CFG_FIVE, 8'h00);
      for (int i = 0; i < 12; i++)
      begin
         r = ROWS[i];
         p = {8'h12, 8'(i)};
         t = {8'h0A, 8'(i)};
         wr(ADDR_CFG_THREE, {4'h0, r.ty, 2'h0});
         wr(ADDR_CFG_FIVE, {r.st, 4'h0});
         rd(ADDR_CFG_FIVE, {r.st, 4'h0});
         pulse(p, t);
         e = !r.live ? r.word : (r.ty == 2'h3 ? t : p);
         chk8("res_low", e[7:0], o_lo);
         chk8("res_high", e[15:8], o_hi);
         chk1("cm_verify", r.fl[2], o_cm);
         chk1("dig_en", r.fl[1], o_dig_en);
         chk1("st_reserved", r.fl[0], o_res);
         if (r.fl[1])
            chk8("dig_num", {6'h00, r.st[1:0]}, {6'h00, o_dig});
      end
      // Type 00 must leave the pair untouched
      wr(ADDR_CFG_FIVE, 8'h00);
      wr(ADDR_CFG_THREE, 8'h04);
      pulse(16'h1111, 16'h2222);
      wr(ADDR_CFG_THREE, 8'h00);
      pulse(16'h3333, 16'h4444);
      chk8("hold_low", 8'h11, o_lo);
      chk8("hold_high", 8'h11, o_hi);
      // Both polarities against both request levels
      for (int k = 0; k < 4; k++)
      begin
         if (k[0] == 1'b0)
            wr(ADDR_CFG_FOUR, {5'h00, k[1], 2'h0});
         @(posedge i_mclk) i_int_req <= k[0];
         @(posedge i_mclk) #1;
         chk1("int_oe", k[0], o_oe);
         chk1("int_out", ~k[1], o_out);
         chk1("pull_up", k[1], o_pu);
         chk1("pull_down", ~k[1], o_pd);
      end
      // Write then read on consecutive edges, reserved bits included
      @(posedge i_mclk) {i_wr_en, i_wdata} <= {1'b1, 8'h84};
      i_addr <= ADDR_CFG_FOUR;
      @(posedge i_mclk) {i_wr_en, i_rd_en} <= 2'b01;
      @(posedge i_mclk) i_rd_en <= 1'b0;
      #1 chk8("rdata_b2b", 8'h84, o_rdata);
      chk1("b2b_pull_up", 1'b1, o_pu);
      wr(ADDR_CFG_FOUR, 8'hFF);
      rd(ADDR_CFG_FOUR, 8'hFF);
      wr(8'h45, 8'h5A);
      rd(8'h45, 8'h00);
      wr(ADDR_CFG_FIVE, 8'hD0);
      // Look once the write and its parity capture have settled
      repeat (2) @(posedge i_mclk);
      #1 chk1("array_err", 1'b0, o_err);
      // Reset in mid-run clears both registers
      @(posedge i_mclk) i_reset_n <= 1'b0;
      @(posedge i_mclk) #1;
      chk1("rst_pull_down", 1'b1, o_pd);
      @(posedge i_mclk) i_reset_n <= 1'b1;
      repeat (3) @(posedge i_mclk);
      rd(ADDR_CFG_FOUR, 8'h00);
      rd(ADDR_CFG_FIVE, 8'h00);
      finish_test();
   end
endmodule // dsp_user_config_regs_test

// ===== dur_config_regs.sv
`timescale 1ns/1ps
module dur_config_regs
   import dur_pkg::*;
#(
   parameter int RW = 16
) (
   input wire logic i_mclk, // 100 MHz clock
   input wire logic i_reset_n, // Async reset, active low
   input wire logic i_wr_en, // Register write strobe
   input wire logic i_rd_en, // Register read strobe
   input wire logic [7:0] i_addr, // Register address
   input wire logic [7:0] i_wdata, // Write data
   output logic [7:0] o_rdata, // Read data, registered
   input wire logic [RW-1:0] i_absolute_pressure, // Pressure result
   input wire logic [RW-1:0] i_temperature, // Temperature result
   input wire logic i_dsp_valid, // New processing result
   output logic [7:0] o_second_result_low_byte, // Result low byte
   output logic [7:0] o_second_result_high_byte, // Result high byte
   output logic o_cm_verify, // Common-mode check active
   output logic [1:0] o_digital_test, // Digital test number
   output logic o_digital_test_en, // Digital test active
   output logic o_self_test_reserved, // Reserved code written
   input wire logic i_int_req, // Interrupt event level
   output logic o_int_out, // Interrupt pin drive level
   output logic o_int_oe, // Interrupt pin enable
   output logic o_int_pull_up, // Weak pull-up enable
   output logic o_int_pull_down, // Weak pull-down enable
   output logic o_array_error // Register integrity fault
);
   import dur_pkg::*;

   logic rst_meta;
   logic rst_n;
   logic [7:0] cfg_three;
   logic [7:0] cfg_four;
   logic [7:0] cfg_five;
   logic [RW-1:0] result;
   logic [RW-1:0] next_result;
   dur_src_t src;
   logic load_four;
   logic load_five;

   // Reset enters asynchronously but is released on the clock
   always_ff @(posedge i_mclk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // Address decode
   wire logic wr_three = i_wr_en && (i_addr == ADDR_CFG_THREE);
   wire logic wr_four = i_wr_en && (i_addr == ADDR_CFG_FOUR);
   wire logic wr_five = i_wr_en && (i_addr == ADDR_CFG_FIVE);

   // Configuration storage; all fields clear at reset
   always_ff @(posedge i_mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cfg_three <= RESET_CFG;
         cfg_four <= RESET_CFG;
         cfg_five <= RESET_CFG;
      end
      else
      begin
         if (wr_three)
            cfg_three <= i_wdata;
         if (wr_four)
            cfg_four <= i_wdata;
         if (wr_five)
            cfg_five <= i_wdata;
      end
   end

   // Read mux; unmapped addresses answer zero
   wire logic [7:0] rd_mux =
      (i_addr == ADDR_CFG_THREE) ? cfg_three :
      (i_addr == ADDR_CFG_FOUR) ? cfg_four :
      (i_addr == ADDR_CFG_FIVE) ? cfg_five : READ_UNMAPPED;

   always_ff @(posedge i_mclk or negedge rst_n)
   begin
      if (!rst_n)
         o_rdata <= READ_UNMAPPED;
      else if (i_rd_en)
         o_rdata <= rd_mux;
   end

   // Field extraction
   wire logic [1:0] type_sel = cfg_three[TYPE_LSB +: 2];
   wire logic int_pol = cfg_four[INT_POL_BIT];
   wire logic [3:0] st_sel = cfg_five[ST_LSB +: 4];

   // Self-test code decode
   wire logic st_pattern = (st_sel[3:2] == ST_PAT_ZERO[3:2]);
   wire logic st_digital = (st_sel == ST_DIG_0) || (st_sel == ST_DIG_1)
      || (st_sel == ST_DIG_2);
   wire logic st_live = (st_sel == ST_NORMAL) || (st_sel == ST_CM_VERIFY);
   // Reserved codes fall back to live data so the path keeps running
   wire logic st_reserved = !st_pattern && !st_digital && !st_live;
   wire logic [RW-1:0] fixed_word =
      (st_sel == ST_PAT_A) ? PAT_A[RW-1:0] :
      (st_sel == ST_PAT_5) ? PAT_5[RW-1:0] :
      (st_sel == ST_PAT_F) ? PAT_F[RW-1:0] :
      (st_sel == ST_DIG_0) ? DIG_0[RW-1:0] :
      (st_sel == ST_DIG_1) ? DIG_1[RW-1:0] :
      (st_sel == ST_DIG_2) ? DIG_2[RW-1:0] : PAT_ZERO[RW-1:0];
   wire logic type_ok = (type_sel == TYPE_PRESSURE)
      || (type_sel == TYPE_TEMPERATURE);

   // Source of the second result pair
   always_comb
   begin
      if (st_pattern || st_digital)
         src = DUR_SRC_FIXED;
      else if (i_dsp_valid && type_ok)
         src = DUR_SRC_LIVE;
      else
         src = DUR_SRC_HOLD;
   end

   always_comb
   begin
      unique case (src)
         DUR_SRC_FIXED: next_result = fixed_word;
         DUR_SRC_LIVE: next_result = (type_sel == TYPE_TEMPERATURE) ?
            i_temperature : i_absolute_pressure;
         DUR_SRC_HOLD: next_result = result;
      endcase
   end

   // Undefined type codes leave the pair unchanged outside the pattern and digital self-test codes
   always_ff @(posedge i_mclk or negedge rst_n)
   begin
      if (!rst_n)
         result <= '0;
      else
         result <= next_result;
   end

   assign o_second_result_low_byte = result[7:0];
   assign o_second_result_high_byte = result[15:8];

   // Self-test status outputs straight from the stored code
   assign o_cm_verify = (st_sel == ST_CM_VERIFY);
   assign o_digital_test_en = st_digital;
   assign o_digital_test = st_sel[1:0];
   assign o_self_test_reserved = st_reserved;

   // Open-drain pin: drive only while asserted, weak pull to idle
   assign o_int_out = !int_pol;
   assign o_int_oe = i_int_req;
   assign o_int_pull_down = !int_pol;
   assign o_int_pull_up = int_pol;

   // Integrity watch; self-test code stays outside the check
   dur_guard_if #(.W(8)) g_four ();
   dur_guard_if #(.W(8)) g_five ();
   // Parity is taken one cycle after a write, once the new word is stored;
   // taking it on the write edge would capture the old contents instead
   always_ff @(posedge i_mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         load_four <= 1'b0;
         load_five <= 1'b0;
      end
      else
      begin
         load_four <= wr_four;
         load_five <= wr_five;
      end
   end

   assign g_four.data = cfg_four;
   assign g_four.load = load_four;
   assign g_five.data = {4'h0, cfg_five[ST_RES_MSB:0]};
   assign g_five.load = load_five;

   dur_parity_guard #(.W(8)) u_guard_four (
      .i_clk(i_mclk),
      .i_rst_n(rst_n),
      .g(g_four)
   );
   dur_parity_guard #(.W(8)) u_guard_five (
      .i_clk(i_mclk),
      .i_rst_n(rst_n),
      .g(g_five)
   );
   assign o_array_error = g_four.error || g_five.error;

   // A plain write must never leave the integrity check complaining
   a_guard_write: assert property (@(posedge i_mclk) disable iff (!rst_n)
      wr_four ##1 !wr_four ##1 !wr_four |-> !g_four.error)
      else $error("config four flagged after a clean write");

   a_type_pressure: assert property (@(posedge i_mclk) disable iff (!rst_n)
      (i_dsp_valid && st_live && type_sel == TYPE_PRESSURE)
      |=> result == $past(i_absolute_pressure))
      else $error("pressure not placed in second pair");
   a_type_temp: assert property (@(posedge i_mclk) disable iff (!rst_n)
      (i_dsp_valid && st_live && type_sel == TYPE_TEMPERATURE)
      |=> result == $past(i_temperature))
      else $error("temperature not placed in second pair");
   a_int_high: assert property (@(posedge i_mclk) disable iff (!rst_n)
      !cfg_four[INT_POL_BIT] |-> o_int_out && o_int_pull_down
      && !o_int_pull_up && (o_int_oe == i_int_req))
      else $error("active high pin mode wrong");
   a_int_low: assert property (@(posedge i_mclk) disable iff (!rst_n)
      cfg_four[INT_POL_BIT] |-> !o_int_out && o_int_pull_up
      && !o_int_pull_down)
      else $error("active low pin mode wrong");
   a_cfg_four_write: assert property (@(posedge i_mclk) disable iff (!rst_n)
      (i_wr_en && i_addr == ADDR_CFG_FOUR) ##1 (i_rd_en
      && i_addr == ADDR_CFG_FOUR) |=> o_rdata == $past(i_wdata, 2))
      else $error("config four readback mismatch");
   a_st_field: assert property (@(posedge i_mclk) disable iff (!rst_n)
      (i_wr_en && i_addr == ADDR_CFG_FIVE)
      |=> o_cm_verify == ($past(i_wdata[7:4]) == ST_CM_VERIFY))
      else $error("self-test field not taken from bits 7:4");
   a_st_digital: assert property (@(posedge i_mclk) disable iff (!rst_n)
      (st_sel == ST_DIG_1) ##1 (st_sel == ST_DIG_1)
      |-> result == DIG_1[RW-1:0])
      else $error("digital test word wrong");
   a_st_pattern: assert property (@(posedge i_mclk) disable iff (!rst_n)
      (st_sel == ST_PAT_A) [*2] |-> result == PAT_A[RW-1:0]
      ##1 (st_sel != ST_PAT_A || $stable(result)))
      else $error("fixed pattern not held");
   a_st_reserved: assert property (@(posedge i_mclk) disable iff (!rst_n)
      (st_sel == 4'h2 || st_sel == 4'h9 || st_sel == 4'hF)
      |-> o_self_test_reserved && !o_digital_test_en)
      else $error("reserved code not flagged");
endmodule // dur_config_regs

// ===== dur_guard_if.sv
`timescale 1ns/1ps
// Word under integrity watch, its load strobe and the mismatch flag
interface dur_guard_if #(parameter int W = 8);
   logic [W-1:0] data;
   logic load;
   logic error;
   modport owner (output data, output load, input error);
   modport guard (input data, input load, output error);
endinterface

// ===== dur_parity_guard.sv
`timescale 1ns/1ps
// Keeps a parity copy of a register; flags any later disagreement
module dur_parity_guard #(
   parameter int W = 8
) (
   input wire logic i_clk, // System clock
   input wire logic i_rst_n, // Synchronised reset, active low
   dur_guard_if.guard g // Watched word
);
   logic ref_par;
   wire logic live_par = ^g.data;

   // Reference parity follows only deliberate writes
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         ref_par <= 1'b0;
      else if (g.load)
         ref_par <= live_par;
   end

   // Error is a level: it stays while the stored word is corrupt
   assign g.error = !g.load && (ref_par != live_par);

   a_parity_mismatch: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (!g.load && (ref_par != ^g.data)) |-> g.error)
      else $error("corrupt word not flagged");
   // Reference must come from the word as stored at the load
   a_parity_capture: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      g.load ##1 $stable(g.data) |-> !g.error)
      else $error("reference parity not taken from stored word");
endmodule // dur_parity_guard

// ===== dur_pkg.sv
// Contract
// - Type code 01 pressure, 11 temperature
// - Polarity 0: open-drain, active high, pull-down
// - Polarity 1: open-drain, active low, pull-up
// - Config four at 43h, resets zero, bit2
// - Config four and five integrity checked; five only on bits 3:0, its self-test code is not checked
// - Config five at 44h, self-test bits 7:4
// - Codes 0000, 0001, 1100-1110 functions
// - Codes 0100-0111 inhibit, show fixed patterns
package dur_pkg;
   localparam logic [7:0] ADDR_CFG_THREE = 8'h42;
   localparam logic [7:0] ADDR_CFG_FOUR = 8'h43;
   localparam logic [7:0] ADDR_CFG_FIVE = 8'h44;
   localparam logic [7:0] RESET_CFG = 8'h00;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;
   localparam int TYPE_LSB = 2;
   localparam int INT_POL_BIT = 2;
   localparam int ST_LSB = 4;
   localparam int ST_RES_MSB = 3;
   localparam logic [1:0] TYPE_PRESSURE = 2'h1;
   localparam logic [1:0] TYPE_TEMPERATURE = 2'h3;
   localparam logic [3:0] ST_NORMAL = 4'h0;
   localparam logic [3:0] ST_CM_VERIFY = 4'h1;
   localparam logic [3:0] ST_PAT_ZERO = 4'h4;
   localparam logic [3:0] ST_PAT_A = 4'h5;
   localparam logic [3:0] ST_PAT_5 = 4'h6;
   localparam logic [3:0] ST_PAT_F = 4'h7;
   localparam logic [3:0] ST_DIG_0 = 4'hC;
   localparam logic [3:0] ST_DIG_1 = 4'hD;
   localparam logic [3:0] ST_DIG_2 = 4'hE;
   localparam logic [15:0] PAT_ZERO = 16'h0000;
   localparam logic [15:0] PAT_A = 16'hAAAA;
   localparam logic [15:0] PAT_5 = 16'h5555;
   localparam logic [15:0] PAT_F = 16'hFFFF;
   localparam logic [15:0] DIG_0 = 16'h8171;
   localparam logic [15:0] DIG_1 = 16'h6C95;
   localparam logic [15:0] DIG_2 = 16'h807A;
   typedef enum {DUR_SRC_HOLD, DUR_SRC_LIVE, DUR_SRC_FIXED} dur_src_t;
endpackage
